// ### design/ethpi_phy_side.sv
/*
  ethpi_phy_side: nibble data path to a tri-speed PHY behind an AHB-Lite slave.
  Assumes tx_link_clock is twice the gig transfer rate at 1000, PHY clock below.
*/
// Function
// - Line rates 10, 100 and 1000 Mbit/s; logic follows selected speed.
// - PHY runs the reduced nibble-wide gigabit mode, not full-width mode.
// - Gigabit data moves over the reduced interface at 125 MHz.
// - Gigabit: PHY gives receive clock, this logic drives transmit clock.
// - Receive data is sampled on the rising edge of phy_rx_clock; gig transmit data changes on the rise of gig_tx_clock_out.
// - At 100 Mbit/s transmit runs from the PHY-supplied transmit clock.
// - Four-bit transmit with enable, four-bit receive with data valid.
`timescale 1ns/1ps
module ethpi_phy_side
  import ethpi_pkg::*;
(
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // transmit link
  input wire logic tx_link_clock,
  output logic gig_tx_clock_out,
  output logic [3:0] tx_nibble,
  output logic tx_frame_enable,
  // receive link
  input wire logic phy_rx_clock,
  input wire logic [3:0] rx_nibble,
  input wire logic rx_frame_valid
);

  // ==========================================================================
  // register decode helper
  function automatic logic ethpi_hit(input logic [31:0] addr, input logic [7:0] ofs);
    ethpi_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
  endfunction : ethpi_hit
  ethpi_word_if tx_up (), tx_down (), rx_up (), rx_down ();
  logic [1:0] speed;
  logic [7:0] frames;
  logic [31:0] tx_word_cap;
  logic [7:0] ph_addr;
  logic [2:0] underrun_sync;
  logic rx_enable, underrun, tx_drop, tx_push, ph_write, rx_pop, underrun_seen, underrun_evt;
  logic tx_rst_meta, tx_rst_n, rx_rst_meta, rx_rst_n;
  logic tx_underrun_tgl;
  // ==========================================================================
  // reset release per link domain: assert at once, release on own clock
  always_ff @(posedge tx_link_clock or negedge hresetn) begin
    if (!hresetn) begin
      tx_rst_meta <= 1'b0;
      tx_rst_n <= 1'b0;
    end else begin
      tx_rst_meta <= 1'b1;
      tx_rst_n <= tx_rst_meta;
    end
  end

  always_ff @(posedge phy_rx_clock or negedge hresetn) begin
    if (!hresetn) begin
      rx_rst_meta <= 1'b0;
      rx_rst_n <= 1'b0;
    end else begin
      rx_rst_meta <= 1'b1;
      rx_rst_n <= rx_rst_meta;
    end
  end
  // ==========================================================================
  // ahb-lite address phase capture; zero wait states, always okay
  wire addr_take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      ph_write <= addr_take && hwrite;
      ph_addr <= (addr_take && hwrite && haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // read data is registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      rx_pop <= 1'b0;
    end else begin
      rx_pop <= 1'b0;
      hrdata <= 32'h00000000;
      if (addr_take && !hwrite) begin
        if (ethpi_hit(haddr, ETHPI_CTRL_OFS)) begin
          hrdata[ETHPI_CTRL_SPEED_LSB +: 2] <= speed;
          hrdata[ETHPI_CTRL_RXEN_BIT] <= rx_enable;
        end else if (ethpi_hit(haddr, ETHPI_STATUS_OFS)) begin
          hrdata[ETHPI_ST_TX_READY_BIT] <= tx_up.ready;
          hrdata[ETHPI_ST_RX_VALID_BIT] <= rx_down.valid;
          hrdata[ETHPI_ST_UNDERRUN_BIT] <= underrun;
          hrdata[ETHPI_ST_TX_DROP_BIT] <= tx_drop;
          hrdata[ETHPI_ST_FRAMES_LSB +: 8] <= frames;
        end else if (ethpi_hit(haddr, ETHPI_RX_DATA_OFS)) begin
          hrdata[ETHPI_WORD_W-1:0] <= rx_down.data;
          hrdata[ETHPI_RXD_VALID_BIT] <= rx_down.valid;
          rx_pop <= rx_down.valid; // reading takes the word
        end
      end
    end
  end
  // control register: speed select and receive enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed <= ETHPI_CTRL_SPEED_RST;
      rx_enable <= ETHPI_CTRL_RXEN_RST;
    end else if (ph_write && ph_addr == ETHPI_CTRL_OFS) begin
      speed <= hwdata[ETHPI_CTRL_SPEED_LSB +: 2];
      rx_enable <= hwdata[ETHPI_CTRL_RXEN_BIT];
    end
  end
  // transmit byte write: accepted only while the crossing is free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_push <= 1'b0;
      tx_word_cap <= 32'h00000000;
    end else begin
      tx_push <= 1'b0;
      if (ph_write && ph_addr == ETHPI_TX_DATA_OFS && tx_up.ready && !tx_push) begin
        tx_push <= 1'b1;
        tx_word_cap <= hwdata;
      end
    end
  end
  assign tx_up.valid = tx_push;
  assign tx_up.data = {1'b0, tx_word_cap[ETHPI_TXD_LAST_BIT], tx_word_cap[7:0]};
  assign rx_down.ready = rx_pop;
  // underrun event from the transmit domain, toggle synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      underrun_sync <= 3'h0;
      underrun_seen <= 1'b0;
    end else begin
      underrun_sync <= {underrun_sync[1:0], tx_underrun_tgl};
      if (underrun_sync[2] == underrun_sync[1]) begin
        underrun_seen <= underrun_sync[2];
      end
    end
  end
  assign underrun_evt = (underrun_sync[2] == underrun_sync[1]) && (underrun_sync[2] != underrun_seen);
  // sticky status: write one to clear, a new event wins over the clear
  wire st_clear = ph_write && ph_addr == ETHPI_STATUS_OFS;
  wire drop_evt = ph_write && ph_addr == ETHPI_TX_DATA_OFS && (!tx_up.ready || tx_push);
  wire frame_evt = rx_pop && rx_down.data[9];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      underrun <= 1'b0;
      tx_drop <= 1'b0;
      frames <= ETHPI_FRAMES_RST;
    end else begin
      if (underrun_evt) begin
        underrun <= 1'b1;
      end else if (st_clear && hwdata[ETHPI_ST_UNDERRUN_BIT]) begin
        underrun <= 1'b0;
      end
      if (drop_evt) begin
        tx_drop <= 1'b1;
      end else if (st_clear && hwdata[ETHPI_ST_TX_DROP_BIT]) begin
        tx_drop <= 1'b0;
      end
      if (frame_evt) begin
        frames <= frames + 8'h01; // wraps
      end
    end
  end
  // ==========================================================================
  // word crossings between the bus and the two link domains
  ethpi_word_cdc u_tx_cdc (
    .src_clock(hclk),
    .src_reset_n(hresetn),
    .up(tx_up.receiver),
    .dst_clock(tx_link_clock),
    .dst_reset_n(tx_rst_n),
    .down(tx_down.sender)
  );
  ethpi_word_cdc u_rx_cdc (
    .src_clock(phy_rx_clock),
    .src_reset_n(rx_rst_n),
    .up(rx_up.receiver),
    .dst_clock(hclk),
    .dst_reset_n(hresetn),
    .down(rx_down.sender)
  );
  // ==========================================================================
  // transmit domain: speed level passes three flops
  logic [1:0] tsp_s1, tsp_s2, tsp_s3, tx_speed;
  logic [7:0] tx_hold;
  logic tx_phase, tx_last;
  ethpi_tx_state_t tx_state;
  always_ff @(posedge tx_link_clock or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      tsp_s1 <= ETHPI_CTRL_SPEED_RST;
      tsp_s2 <= ETHPI_CTRL_SPEED_RST;
      tsp_s3 <= ETHPI_CTRL_SPEED_RST;
      tx_speed <= ETHPI_CTRL_SPEED_RST;
    end else begin
      tsp_s1 <= speed;
      tsp_s2 <= tsp_s1;
      tsp_s3 <= tsp_s2;
      if (tsp_s2 == tsp_s3) begin
        tx_speed <= tsp_s3;
      end
    end
  end
  wire tx_gig = (tx_speed == ETHPI_SPEED_1000);
  // gigabit steps every other edge; slower rates every edge of the phy clock
  wire tx_step = tx_gig ? !tx_phase : 1'b1;
  wire tx_may_take = (tx_state == ETHPI_TX_IDLE) || (tx_state == ETHPI_TX_NEXT && !tx_last);
  assign tx_down.ready = tx_step && tx_may_take && tx_down.valid;
  // forwarded transmit clock rises on the edge that launches the nibble
  always_ff @(posedge tx_link_clock or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      tx_phase <= 1'b0;
      gig_tx_clock_out <= 1'b0;
    end else begin
      tx_phase <= tx_gig ? ~tx_phase : 1'b0;
      gig_tx_clock_out <= tx_gig && !tx_phase;
    end
  end
  // nibble sequencer: low nibble then high nibble of each byte
  always_ff @(posedge tx_link_clock or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      tx_state <= ETHPI_TX_IDLE;
      tx_nibble <= 4'h0;
      tx_frame_enable <= 1'b0;
      tx_hold <= 8'h00;
      tx_last <= 1'b0;
      tx_underrun_tgl <= 1'b0;
    end else if (tx_step) begin
      case (tx_state)
        ETHPI_TX_IDLE: begin
          tx_frame_enable <= 1'b0;
          tx_nibble <= 4'h0;
          if (tx_down.valid) begin
            tx_hold <= tx_down.data[7:0];
            tx_last <= tx_down.data[8];
            tx_nibble <= tx_down.data[3:0];
            tx_frame_enable <= 1'b1;
            tx_state <= ETHPI_TX_HIGH;
          end
        end
        ETHPI_TX_HIGH: begin
          tx_nibble <= tx_hold[7:4];
          tx_state <= ETHPI_TX_NEXT;
        end
        ETHPI_TX_NEXT: begin
          if (!tx_last && tx_down.valid) begin
            tx_hold <= tx_down.data[7:0];
            tx_last <= tx_down.data[8];
            tx_nibble <= tx_down.data[3:0];
            tx_state <= ETHPI_TX_HIGH;
          end else begin
            tx_frame_enable <= 1'b0;
            tx_nibble <= 4'h0;
            tx_state <= ETHPI_TX_IDLE;
            if (!tx_last) begin
              tx_underrun_tgl <= ~tx_underrun_tgl; // frame cut short
            end
          end
        end
        default: begin
          tx_state <= ETHPI_TX_IDLE;
          tx_frame_enable <= 1'b0;
        end
      endcase
    end
  end
  // ==========================================================================
  // receive domain: enable level passes three flops
  logic ren_s1, ren_s2, ren_s3, rx_en, rx_in_frame, rx_half, rx_lost, rx_push;
  logic [3:0] rx_low;
  logic [ETHPI_WORD_W-1:0] rx_word;
  always_ff @(posedge phy_rx_clock or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      ren_s1 <= 1'b0;
      ren_s2 <= 1'b0;
      ren_s3 <= 1'b0;
      rx_en <= 1'b0;
    end else begin
      ren_s1 <= rx_enable;
      ren_s2 <= ren_s1;
      ren_s3 <= ren_s2;
      if (ren_s2 == ren_s3) begin
        rx_en <= ren_s3;
      end
    end
  end
  assign rx_up.valid = rx_push;
  assign rx_up.data = rx_word;
  // pair nibbles into bytes on the rising receive edge; mark frame end
  always_ff @(posedge phy_rx_clock or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rx_in_frame <= 1'b0;
      rx_half <= 1'b0;
      rx_low <= 4'h0;
      rx_lost <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= '0;
    end else begin
      if (rx_push && !rx_up.ready) begin
        rx_lost <= 1'b1; // crossing busy, word dropped
      end
      rx_push <= 1'b0;
      if (rx_frame_valid && (rx_en || rx_in_frame)) begin
        rx_in_frame <= 1'b1;
        if (!rx_in_frame) begin
          rx_lost <= 1'b0;
        end
        if (!rx_half) begin
          rx_low <= rx_nibble; // low nibble first
          rx_half <= 1'b1;
        end else begin
          rx_half <= 1'b0;
          rx_word <= {ETHPI_KIND_BYTE, rx_nibble, rx_low};
          rx_push <= 1'b1;
        end
      end else if (rx_in_frame) begin
        rx_in_frame <= 1'b0;
        rx_half <= 1'b0;
        rx_push <= 1'b1;
        if (rx_lost || rx_half || (rx_push && !rx_up.ready)) begin
          rx_word <= {ETHPI_KIND_END_LOST, 8'h00};
        end else begin
          rx_word <= {ETHPI_KIND_END_OK, 8'h00};
        end
      end
    end
  end
endmodule : ethpi_phy_side

// ### design/ethpi_pkg.sv
/*
  ethpi_pkg: constants and types of the PHY-side Ethernet block.
  Assumes a 32-bit register bus and a nibble-wide PHY path.
*/
package ethpi_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ETHPI_CTRL_OFS = 8'h00;
  localparam logic [7:0] ETHPI_STATUS_OFS = 8'h04;
  localparam logic [7:0] ETHPI_TX_DATA_OFS = 8'h08;
  localparam logic [7:0] ETHPI_RX_DATA_OFS = 8'h0C;

  // ==========================================================================
  // line rate codes in the control register
  localparam logic [1:0] ETHPI_SPEED_10 = 2'h0;
  localparam logic [1:0] ETHPI_SPEED_100 = 2'h1;
  localparam logic [1:0] ETHPI_SPEED_1000 = 2'h2;

  // ==========================================================================
  // field positions
  localparam int ETHPI_CTRL_SPEED_LSB = 0;
  localparam int ETHPI_CTRL_RXEN_BIT = 2;
  localparam int ETHPI_ST_TX_READY_BIT = 0;
  localparam int ETHPI_ST_RX_VALID_BIT = 1;
  localparam int ETHPI_ST_UNDERRUN_BIT = 2;
  localparam int ETHPI_ST_TX_DROP_BIT = 3;
  localparam int ETHPI_ST_FRAMES_LSB = 8;
  localparam int ETHPI_TXD_LAST_BIT = 8;
  localparam int ETHPI_RXD_VALID_BIT = 31;

  // ==========================================================================
  // values after reset
  localparam logic [1:0] ETHPI_CTRL_SPEED_RST = ETHPI_SPEED_1000;
  localparam logic ETHPI_CTRL_RXEN_RST = 1'b0;
  localparam logic [7:0] ETHPI_FRAMES_RST = 8'h00;

  // ==========================================================================
  // crossing words: byte in [7:0], kind in [9:8]
  localparam int ETHPI_WORD_W = 10;
  localparam logic [1:0] ETHPI_KIND_BYTE = 2'h1;
  localparam logic [1:0] ETHPI_KIND_END_OK = 2'h2;
  localparam logic [1:0] ETHPI_KIND_END_LOST = 2'h3;

  // ==========================================================================
  // link facts
  localparam logic [2:0] ETHPI_PHY_MGMT_ADDR = 3'h3;
  localparam int ETHPI_GIG_XFER_MHZ = 125;
  localparam int ETHPI_FAST_XFER_MHZ = 25;

  // transmit sequencing states
  typedef enum logic [1:0] {
    ETHPI_TX_IDLE,
    ETHPI_TX_HIGH,
    ETHPI_TX_NEXT
  } ethpi_tx_state_t;

endpackage : ethpi_pkg

// ### design/ethpi_word_if.sv
/*
  ethpi_word_if: valid/ready word channel between the block's modules.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface ethpi_word_if;
  import ethpi_pkg::*;
  logic [ETHPI_WORD_W-1:0] data;
  logic valid;
  logic ready;
  modport sender (output data, output valid, input ready);
  modport receiver (input data, input valid, output ready);
endinterface : ethpi_word_if

// ### design/ethpi_word_cdc.sv
/*
  ethpi_word_cdc: toggle-handshake word crossing between two clocks.
  Assumes each reset is released in its own domain.
*/
`timescale 1ns/1ps
module ethpi_word_cdc
  import ethpi_pkg::*;
(
  // source domain
  input wire logic src_clock,
  input wire logic src_reset_n,
  ethpi_word_if.receiver up,
  // destination domain
  input wire logic dst_clock,
  input wire logic dst_reset_n,
  ethpi_word_if.sender down
);

  logic [ETHPI_WORD_W-1:0] hold;
  logic req;
  logic [2:0] ack_sync;
  logic ack_seen;
  logic [2:0] req_sync;
  logic req_seen;
  logic [ETHPI_WORD_W-1:0] out_data;
  logic out_valid;
  logic ack;

  // ==========================================================================
  // source side: capture and toggle the request while idle
  assign up.ready = (req == ack_seen);

  always_ff @(posedge src_clock or negedge src_reset_n) begin
    if (!src_reset_n) begin
      hold <= '0;
      req <= 1'b0;
    end else if (up.valid && up.ready) begin
      hold <= up.data; // stable until acknowledged
      req <= ~req;
    end
  end

  // acknowledge back into the source domain
  always_ff @(posedge src_clock or negedge src_reset_n) begin
    if (!src_reset_n) begin
      ack_sync <= 3'h0;
      ack_seen <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[1:0], ack};
      if (ack_sync[2] == ack_sync[1]) begin
        ack_seen <= ack_sync[2];
      end
    end
  end

  // ==========================================================================
  // destination side: present the word until the drain takes it
  always_ff @(posedge dst_clock or negedge dst_reset_n) begin
    if (!dst_reset_n) begin
      req_sync <= 3'h0;
      req_seen <= 1'b0;
      out_data <= '0;
      out_valid <= 1'b0;
      ack <= 1'b0;
    end else begin
      req_sync <= {req_sync[1:0], req};
      if (out_valid && down.ready) begin
        out_valid <= 1'b0;
        ack <= ~ack; // frees the source only once consumed
      end else if (!out_valid && (req_sync[2] == req_sync[1]) && (req_sync[2] != req_seen)) begin
        req_seen <= req_sync[2];
        out_data <= hold;
        out_valid <= 1'b1;
      end
    end
  end

  assign down.data = out_data;
  assign down.valid = out_valid;

endmodule : ethpi_word_cdc

// ### tb/ethpi_phy_side_assertions.sv
/*
  ethpi_phy_side_assertions: port-level checks of ethpi_phy_side.
  Assumes binding into that module.
*/
`timescale 1ns/1ps
module ethpi_phy_side_assertions
  import ethpi_pkg::*;
(
  // bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // transmit link
  input wire logic tx_link_clock,
  input wire logic gig_tx_clock_out,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_frame_enable
);
  // ==========================================================================
  // bus side
  // a read taken at this edge
  wire rd_req = hsel && htrans[1] && hready && !hwrite;
  property p_okay;
    @(posedge hclk) disable iff (!hresetn) hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_ready;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_idle_data;
    @(posedge hclk) disable iff (!hresetn) !$past(rd_req) |-> hrdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside data phase");
  property p_write_only;
    @(posedge hclk) disable iff (!hresetn)
      $past(rd_req) && $past(haddr) == 32'h8 |-> hrdata == 32'h0;
  endproperty
  a_write_only: assert property (p_write_only) else $error("transmit word reads nonzero");
  property p_status_spare;
    @(posedge hclk) disable iff (!hresetn)
      $past(rd_req) && $past(haddr) == 32'h4 |-> hrdata[31:16] == 16'h0 && hrdata[7:4] == 4'h0;
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("spare status bits set");
  property p_rx_word;
    @(posedge hclk) disable iff (!hresetn)
      $past(rd_req) && $past(haddr) == 32'hC && hrdata[31] |->
      hrdata[9:8] != 2'h0 && hrdata[30:10] == 21'h0;
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("bad receive word");
  // ==========================================================================
  // transmit link
  sequence s_gig_byte;
    tx_frame_enable [*3];
  endsequence
  sequence s_fast_byte;
    tx_frame_enable;
  endsequence
  property p_idle_zero;
    @(posedge tx_link_clock) disable iff (!hresetn) !tx_frame_enable |-> tx_nibble == 4'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("nibble outside frame");
  property p_gig_half;
    @(posedge tx_link_clock) disable iff (!hresetn)
      $rose(gig_tx_clock_out) |=> $fell(gig_tx_clock_out);
  endproperty
  a_gig_half: assert property (p_gig_half) else $error("gig clock not half rate");
  property p_aligned;
    @(posedge tx_link_clock) disable iff (!hresetn)
      $fell(gig_tx_clock_out) |-> $stable(tx_nibble) && $stable(tx_frame_enable);
  endproperty
  a_aligned: assert property (p_aligned) else $error("data moved off clock rise");
  property p_gig_byte;
    @(posedge tx_link_clock) disable iff (!hresetn)
      $rose(tx_frame_enable) && gig_tx_clock_out |=> s_gig_byte;
  endproperty
  a_gig_byte: assert property (p_gig_byte) else $error("short gig byte");
  property p_fast_byte;
    @(posedge tx_link_clock) disable iff (!hresetn)
      $rose(tx_frame_enable) && !gig_tx_clock_out |=> s_fast_byte;
  endproperty
  a_fast_byte: assert property (p_fast_byte) else $error("short fast byte");
endmodule : ethpi_phy_side_assertions

bind ethpi_phy_side ethpi_phy_side_assertions u_chk (.*);

// ### tb/ethpi_phy_model.sv
/*
  ethpi_phy_model: behavioural tri-speed PHY on the nibble side.
  Assumes the bench sets gig_mode and calls send_frame.
*/
`timescale 1ns/1ps
module ethpi_phy_model
  import ethpi_pkg::*;
(
  // transmit side from the block
  input wire logic tx_link_clock,
  input wire logic gig_mode,
  input wire logic gig_tx_clock_out,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_frame_enable,
  // receive side toward the block
  output logic phy_rx_clock,
  output logic [3:0] rx_nibble,
  output logic rx_frame_valid
);
  // management frames answered at the strapped address only; port left out
  localparam logic [2:0] MGMT_ADDR = ETHPI_PHY_MGMT_ADDR;
  logic [7:0] got [$];
  int frames = 0;
  logic half = 1'b0;
  logic in_frame = 1'b0;
  logic [3:0] low;
  // clock parked low and data lines scrambled between frames
  initial begin
    phy_rx_clock = 1'b0;
    rx_nibble = 4'hA;
    rx_frame_valid = 1'b0;
  end
  // ==========================================================================
  // transmit capture on rising edges; gig steps only while its clock is high
  always @(posedge tx_link_clock) begin
    if (tx_frame_enable && (!gig_mode || gig_tx_clock_out)) begin
      if (half) got.push_back({tx_nibble, low});
      low = tx_nibble;
      half = !half;
      in_frame = 1'b1;
    end else if (!tx_frame_enable && in_frame) begin
      in_frame = 1'b0;
      half = 1'b0;
      frames++;
    end
  end
  // one receive clock cycle sourced here; data moves while it is low
  task automatic tick(input int hp);
    #(hp) phy_rx_clock = 1'b1;
    #(hp) phy_rx_clock = 1'b0;
  endtask : tick
  // idle edges, optional byte low nibble first, optional stray nibble
  task automatic send_frame(input logic [7:0] b, input logic one, input logic stray,
      input int hp);
    repeat (8) tick(hp);
    rx_frame_valid = 1'b1;
    if (one) begin
      rx_nibble = b[3:0];
      tick(hp);
      rx_nibble = b[7:4];
      tick(hp);
    end
    if (stray) begin
      rx_nibble = ~b[3:0];
      tick(hp);
    end
    rx_frame_valid = 1'b0;
    rx_nibble = ~rx_nibble;
    repeat (8) tick(hp);
  endtask : send_frame
endmodule : ethpi_phy_model

// ### tb/ethpi_phy_side_test.sv
/*
  ethpi_phy_side_test: self-checking bench for ethpi_phy_side.
  Assumes the bound checker and the PHY model.
*/
`timescale 1ns/1ps
module ethpi_phy_side_test;
  import ethpi_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_link_clock, gig_mode;
  logic gig_tx_clock_out, tx_frame_enable, phy_rx_clock, rx_frame_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tx_nibble, rx_nibble;
  logic [7:0] b, f0;
  logic [1:0] speeds [4] = '{ETHPI_SPEED_100, ETHPI_SPEED_1000, ETHPI_SPEED_10, 2'h3};
  int hps [3] = '{200, 500 / ETHPI_FAST_XFER_MHZ, 500 / ETHPI_GIG_XFER_MHZ};
  int errors = 0;
  int n_compared = 0;
  int seed = 32;
  ethpi_phy_side dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_link_clock, .gig_tx_clock_out,
    .tx_nibble, .tx_frame_enable, .phy_rx_clock, .rx_nibble, .rx_frame_valid);
  ethpi_phy_model phy (.tx_link_clock, .gig_mode, .gig_tx_clock_out, .tx_nibble,
    .tx_frame_enable, .phy_rx_clock, .rx_nibble, .rx_frame_valid);
  // bus clock and unrelated transmit link clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    tx_link_clock = 1'b0;
    #7;
    forever #24 tx_link_clock = ~tx_link_clock;
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'h000000, o};
  endfunction : ad
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // wait for hready at a rising edge
  task automatic wait_ready;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_ready
  // one single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  task automatic rdw(input logic [7:0] o);
    ahb(1'b0, ad(o), 32'h0);
  endtask : rdw
  // write a transmit word, wait for the frame at the phy, then for tx_ready
  task automatic tx_byte(input logic [8:0] w, input logic [7:0] want);
    int n0 = phy.frames;
    int n = 0;
    ahb(1'b1, ad(ETHPI_TX_DATA_OFS), {23'h0, w});
    while (phy.frames == n0 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, phy.got.size() == 1}, 32'h1);
    if (phy.got.size() > 0) check({24'h0, phy.got.pop_front()}, {24'h0, want});
    n = 0;
    do begin
      rdw(ETHPI_STATUS_OFS);
      n++;
    end while (rd[0] !== 1'b1 && n < 100);
    check({31'h0, rd[0]}, 32'h1);
  endtask : tx_byte
  // send a receive frame, poll the first word, then drain
  task automatic rx_frame(input logic [7:0] v, input logic one, input int hp,
      input logic [31:0] want);
    int n = 0;
    phy.send_frame(v, one, !one, hp);
    do begin
      rdw(ETHPI_RX_DATA_OFS);
      n++;
    end while (rd[31] !== 1'b1 && n < 20);
    check(rd & (one ? 32'h800003FF : 32'h80000300), want);
    repeat (4) rdw(ETHPI_RX_DATA_OFS);
  endtask : rx_frame
  // watchdog
  initial begin
    #5000000;
    errors++;
    give_verdict();
  end
  // ==========================================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    gig_mode = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped place, write-only word
    rdw(ETHPI_CTRL_OFS);
    check(rd, {29'h0, ETHPI_CTRL_RXEN_RST, ETHPI_CTRL_SPEED_RST});
    rdw(ETHPI_STATUS_OFS);
    check(rd, 32'h1);
    ahb(1'b1, 32'h10, $random(seed));
    rdw(8'h10);
    check(rd, 32'h0);
    rdw(ETHPI_TX_DATA_OFS);
    check(rd, 32'h0);
    // single-byte frames at every speed code
    foreach (speeds[i]) begin
      gig_mode <= (speeds[i] == ETHPI_SPEED_1000);
      ahb(1'b1, ad(ETHPI_CTRL_OFS), {30'h0, speeds[i]});
      repeat (3) begin
        b = $random(seed);
        tx_byte({1'b1, b}, b);
      end
    end
    // underrun: byte without last, then clear the sticky flag
    gig_mode <= 1'b0;
    ahb(1'b1, ad(ETHPI_CTRL_OFS), {30'h0, ETHPI_SPEED_100});
    b = $random(seed);
    tx_byte({1'b0, b}, b);
    rdw(ETHPI_STATUS_OFS);
    check(rd & 32'hC, 32'h4);
    ahb(1'b1, ad(ETHPI_STATUS_OFS), 32'h4);
    rdw(ETHPI_STATUS_OFS);
    check(rd & 32'hC, 32'h0);
    // back-to-back writes: second dropped
    b = $random(seed);
    ahb(1'b1, ad(ETHPI_TX_DATA_OFS), {23'h1, b});
    tx_byte({1'b1, ~b}, b);
    rdw(ETHPI_STATUS_OFS);
    check(rd & 32'hC, 32'h8);
    ahb(1'b1, ad(ETHPI_STATUS_OFS), 32'h8);
    // receive with enable at 10, 100 and 1000 rates
    ahb(1'b1, ad(ETHPI_CTRL_OFS), {29'h1, ETHPI_SPEED_100});
    foreach (hps[i]) begin
      b = $random(seed);
      rx_frame(b, 1'b1, hps[i], {1'b1, 21'h0, ETHPI_KIND_BYTE, b});
    end
    // lone nibble ends as lost and counts one frame
    rdw(ETHPI_STATUS_OFS);
    f0 = rd[15:8];
    rx_frame(8'h5, 1'b0, hps[1], {1'b1, 21'h0, ETHPI_KIND_END_LOST, 8'h0});
    rdw(ETHPI_STATUS_OFS);
    check({24'h0, rd[15:8]}, {24'h0, f0 + 8'h1});
    // receive disabled: nothing arrives
    ahb(1'b1, ad(ETHPI_CTRL_OFS), {30'h0, ETHPI_SPEED_100});
    phy.send_frame($random(seed), 1'b1, 1'b0, hps[1]);
    repeat (10) @(posedge hclk);
    rdw(ETHPI_RX_DATA_OFS);
    check(rd & 32'h80000000, 32'h0);
    give_verdict();
  end
endmodule : ethpi_phy_side_test
